// >>> pkg/fwsp_pkg.sv
// Package: register map, field positions, reset values and carrier types of the four-wire serial port.
package fwsp_pkg;

   // -----------------------------------------------------------------------------------------
   // Register word addresses
   // -----------------------------------------------------------------------------------------
   localparam logic [15:0] OFS_CONFIG     = 16'h7040;
   localparam logic [15:0] OFS_CONTROL    = 16'h7041;
   localparam logic [15:0] OFS_STATUS     = 16'h7042;
   localparam logic [15:0] OFS_RATE       = 16'h7044;
   localparam logic [15:0] OFS_RX_EMU     = 16'h7046;
   localparam logic [15:0] OFS_RX_BUF     = 16'h7047;
   localparam logic [15:0] OFS_TX_BUF     = 16'h7048;
   localparam logic [15:0] OFS_SHIFT      = 16'h7049;
   localparam int unsigned MISC_NUM       = 4;
   localparam logic [15:0] MISC_OFS [MISC_NUM] = '{16'h704a, 16'h704b, 16'h704c, 16'h704f};

   // -----------------------------------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------------------------------
   localparam int unsigned CCR_ENABLE     = 7;
   localparam int unsigned CCR_POLARITY   = 6;
   localparam int unsigned CCR_LEN_W      = 4;
   localparam int unsigned CTL_THREE_WIRE = 4;
   localparam int unsigned CTL_PHASE      = 3;
   localparam int unsigned CTL_MASTER     = 2;
   localparam int unsigned CTL_TALK       = 1;
   localparam int unsigned CTL_RX_IE      = 0;
   localparam int unsigned STS_OVERRUN    = 7;
   localparam int unsigned STS_RX_READY   = 6;
   localparam int unsigned STS_TX_FULL    = 5;

   // -----------------------------------------------------------------------------------------
   // Widths, reset values and rate floor
   // -----------------------------------------------------------------------------------------
   localparam int unsigned REG_W          = 16;
   localparam int unsigned BYTE_W         = 8;
   localparam int unsigned RATE_W         = 7;
   localparam int unsigned RATE_FLOOR     = 3;
   localparam logic [7:0]  CONFIG_RST     = 8'h00;
   localparam logic [7:0]  CONTROL_RST    = 8'h00;
   localparam logic [6:0]  RATE_RST       = 7'h00;
   localparam logic [7:0]  BYTE_RST       = 8'h00;
   localparam logic [15:0] WORD_RST       = 16'h0000;

   // -----------------------------------------------------------------------------------------
   // Types
   // -----------------------------------------------------------------------------------------
   typedef enum logic {FWSP_IDLE, FWSP_XFER} fwsp_state_t;

   typedef struct packed {
      logic sck;
      logic simo;
      logic somi;
      logic ste;
   } fwsp_pins_t;

   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [15:0] addr;
      logic [15:0] data;
   } fwsp_bus_req_t;

   localparam fwsp_pins_t PIN_OUT_RST = '{sck: 1'b0, simo: 1'b0, somi: 1'b0, ste: 1'b1};
   localparam fwsp_pins_t PIN_OE_RST  = '{sck: 1'b0, simo: 1'b0, somi: 1'b0, ste: 1'b0};

endpackage : fwsp_pkg

// >>> verilog/fwsp_rate_gen.sv
// Serial clock rate generator: one period of setting plus one input clocks (settings below 3 act as 3), with mid and end ticks.
`timescale 1ns/10ps
`default_nettype none
module fwsp_rate_gen #(
   parameter int unsigned DIV_W = 7
) (
   input  wire logic             clk_sys,
   input  wire logic             nrst,
   input  wire logic             run,
   input  wire logic [DIV_W-1:0] divider,
   output logic                  tickLead,
   output logic                  tickEnd
);
   import fwsp_pkg::*;

   logic [DIV_W-1:0] cnt_r;
   logic [DIV_W-1:0] cnt_nxt;
   logic [DIV_W-1:0] lastCnt;
   logic [DIV_W-1:0] halfCnt;

   // Odd periods give the idle half one cycle more than the active half.
   always_comb begin
      lastCnt  = (divider < DIV_W'(RATE_FLOOR)) ? DIV_W'(RATE_FLOOR) : divider;
      halfCnt  = lastCnt >> 1;
      tickLead = run && (cnt_r == halfCnt);
      tickEnd  = run && (cnt_r == lastCnt);
      if (!run || tickEnd) begin
         cnt_nxt = '0;
      end else begin
         cnt_nxt = DIV_W'(cnt_r + 1'b1);
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

endmodule : fwsp_rate_gen
`default_nettype wire

// >>> verilog/fwsp_top.sv
// Four-wire serial port: register file, master and slave shift engine and pin drive.
`timescale 1ns/10ps
`default_nettype none
module fwsp_top (
   input  wire logic                   clk_sys,
   input  wire logic                   nrst,
   input  wire fwsp_pkg::fwsp_bus_req_t busReq,
   output logic [15:0]                 rdData,
   input  wire fwsp_pkg::fwsp_pins_t   pinIn,
   output fwsp_pkg::fwsp_pins_t        pinOut,
   output fwsp_pkg::fwsp_pins_t        pinOe,
   output logic                        pinOwned,
   output logic                        intReq
);
   import fwsp_pkg::*;

   // -----------------------------------------------------------------------------------------
   // State
   // -----------------------------------------------------------------------------------------
   logic [7:0]        cfg_r;
   logic [7:0]        cfg_nxt;
   logic [7:0]        ctl_r;
   logic [7:0]        ctl_nxt;
   logic [6:0]        rate_r;
   logic [6:0]        rate_nxt;
   logic [7:0]        misc_r [MISC_NUM];
   logic [7:0]        misc_nxt [MISC_NUM];
   logic [7:0]        txBuf_r;
   logic [7:0]        txBuf_nxt;
   logic              txFull_r;
   logic              txFull_nxt;
   logic [7:0]        rxBuf_r;
   logic [7:0]        rxBuf_nxt;
   logic              rxReady_r;
   logic              rxReady_nxt;
   logic              overrun_r;
   logic              overrun_nxt;
   fwsp_state_t       state_r;
   fwsp_state_t       state_nxt;
   logic [3:0]        cnt_r;
   logic [3:0]        cnt_nxt;
   logic [15:0]       txSh_r;
   logic [15:0]       txSh_nxt;
   logic [15:0]       rxSh_r;
   logic [15:0]       rxSh_nxt;
   logic              outBit_r;
   logic              outBit_nxt;
   logic              first_r;
   logic              first_nxt;
   logic              datPend_r;
   logic              datPend_nxt;
   logic              sckPrev_r;
   logic              sckPrev_nxt;
   fwsp_pins_t        pinOut_r;
   fwsp_pins_t        pinOut_nxt;
   fwsp_pins_t        pinOe_r;
   fwsp_pins_t        pinOe_nxt;
   logic [15:0]       rdData_r;
   logic [15:0]       rdData_nxt;
   logic              pinOwned_r;
   logic              pinOwned_nxt;
   logic              intReq_r;
   logic              intReq_nxt;

   // -----------------------------------------------------------------------------------------
   // Decoded controls and events
   // -----------------------------------------------------------------------------------------
   logic              enable;
   logic              polarity;
   logic              phase;
   logic              master;
   logic              talk;
   logic              threeWire;
   logic [3:0]        lenM1;
   logic [15:0]       lenMask;
   logic [7:0]        wrByte;
   logic              inBit;
   logic              slvSel;
   logic              sckEdge;
   logic              lead;
   logic              trail;
   logic              tickLead;
   logic              tickEnd;
   logic              rateRun;
   logic              setRx;
   logic              clrRx;
   logic              setOvr;
   logic              clrOvr;
   logic              setTxFull;
   logic              loadTx;
   logic              datWr;

   assign rateRun = enable && master && (state_r == FWSP_XFER);

   fwsp_rate_gen #(
      .DIV_W    (RATE_W)
   ) u_rate (
      .clk_sys  (clk_sys),
      .nrst     (nrst),
      .run      (rateRun),
      .divider  (rate_r),
      .tickLead (tickLead),
      .tickEnd  (tickEnd)
   );

   // -----------------------------------------------------------------------------------------
   // Next-state logic
   // -----------------------------------------------------------------------------------------
   always_comb begin
      cfg_nxt      = cfg_r;
      ctl_nxt      = ctl_r;
      rate_nxt     = rate_r;
      misc_nxt     = misc_r;
      txBuf_nxt    = txBuf_r;
      rxBuf_nxt    = rxBuf_r;
      state_nxt    = state_r;
      cnt_nxt      = cnt_r;
      txSh_nxt     = txSh_r;
      rxSh_nxt     = rxSh_r;
      outBit_nxt   = outBit_r;
      first_nxt    = 1'b0;
      datPend_nxt  = datPend_r;
      rdData_nxt   = rdData_r;
      setRx        = 1'b0;
      clrRx        = 1'b0;
      setOvr       = 1'b0;
      clrOvr       = 1'b0;
      setTxFull    = 1'b0;
      loadTx       = 1'b0;
      datWr        = 1'b0;

      enable    = cfg_r[CCR_ENABLE];
      polarity  = cfg_r[CCR_POLARITY];
      lenM1     = cfg_r[CCR_LEN_W-1:0];
      phase     = ctl_r[CTL_PHASE];
      master    = ctl_r[CTL_MASTER];
      talk      = ctl_r[CTL_TALK];
      threeWire = ctl_r[CTL_THREE_WIRE];
      lenMask   = 16'hffff >> (4'hf - lenM1);
      wrByte    = busReq.data[BYTE_W-1:0];
      sckPrev_nxt = pinIn.sck;

      // In three-wire mode the master shares its output line and the slave its output line.
      if (master) begin
         inBit = threeWire ? pinIn.simo : pinIn.somi;
      end else begin
         inBit = threeWire ? pinIn.somi : pinIn.simo;
      end

      slvSel  = !pinIn.ste;
      sckEdge = (pinIn.sck != sckPrev_r) && slvSel;
      if (master) begin
         lead  = tickLead;
         trail = tickEnd;
      end else begin
         lead  = sckEdge && (pinIn.sck != polarity);
         trail = sckEdge && (pinIn.sck == polarity);
      end

      // Register writes take the low byte only.
      if (busReq.wr) begin
         case (busReq.addr)
            OFS_CONFIG:  cfg_nxt = wrByte;
            OFS_CONTROL: ctl_nxt = {3'h0, wrByte[4:0]};
            OFS_STATUS:  clrOvr = wrByte[STS_OVERRUN];
            OFS_RATE:    rate_nxt = wrByte[RATE_W-1:0];
            OFS_TX_BUF: begin
               txBuf_nxt = wrByte;
               setTxFull = 1'b1;
            end
            OFS_SHIFT: begin
               datWr = (state_r == FWSP_IDLE);
            end
            default: begin
               for (int i = 0; i < MISC_NUM; i++) begin
                  if (busReq.addr == MISC_OFS[i]) begin
                     misc_nxt[i] = wrByte;
                  end
               end
            end
         endcase
      end
      if (datWr) begin
         txSh_nxt    = {8'h00, wrByte};
         datPend_nxt = 1'b1;
      end

      // Register reads return the low byte with the upper byte zero.
      if (busReq.rd) begin
         rdData_nxt = WORD_RST;
         case (busReq.addr)
            OFS_CONFIG:  rdData_nxt[7:0] = cfg_r;
            OFS_CONTROL: rdData_nxt[7:0] = ctl_r;
            OFS_STATUS:  rdData_nxt[7:0] = {overrun_r, rxReady_r, txFull_r, 5'h00};
            OFS_RATE:    rdData_nxt[7:0] = {1'b0, rate_r};
            OFS_RX_EMU:  rdData_nxt[7:0] = rxBuf_r;
            OFS_RX_BUF: begin
               rdData_nxt[7:0] = rxBuf_r;
               clrRx           = 1'b1;
            end
            OFS_TX_BUF:  rdData_nxt[7:0] = txBuf_r;
            OFS_SHIFT:   rdData_nxt[7:0] = txSh_r[7:0];
            default: begin
               for (int i = 0; i < MISC_NUM; i++) begin
                  if (busReq.addr == MISC_OFS[i]) begin
                     rdData_nxt[7:0] = misc_r[i];
                  end
               end
            end
         endcase
      end

      // Shift engine. Both directions move on every word; talk only gates the pin drive.
      unique case (state_r)
         FWSP_IDLE: begin
            if (enable && !datWr && ((master && (txFull_r || datPend_r)) || (!master && slvSel))) begin
               if (txFull_r && !datPend_r) begin
                  txSh_nxt = {8'h00, txBuf_r};
                  loadTx   = 1'b1;
               end
               datPend_nxt = 1'b0;
               cnt_nxt     = lenM1;
               first_nxt   = 1'b1;
               state_nxt   = FWSP_XFER;
            end
         end
         FWSP_XFER: begin
            if (!enable || (!master && !slvSel)) begin
               state_nxt = FWSP_IDLE;
            end else begin
               if (first_r && phase) begin
                  outBit_nxt = txSh_r[cnt_r];
               end
               if (lead) begin
                  if (phase) begin
                     rxSh_nxt = {rxSh_r[14:0], inBit};
                  end else begin
                     outBit_nxt = txSh_r[cnt_r];
                  end
               end
               if (trail) begin
                  if (!phase) begin
                     rxSh_nxt = {rxSh_r[14:0], inBit};
                  end
                  if (cnt_r == 4'h0) begin
                     rxBuf_nxt = rxSh_nxt[7:0] & lenMask[7:0];
                     setRx     = 1'b1;
                     setOvr    = rxReady_r && !clrRx;
                     state_nxt = FWSP_IDLE;
                  end else begin
                     cnt_nxt = 4'(cnt_r - 4'h1);
                     if (phase) begin
                        outBit_nxt = txSh_r[4'(cnt_r - 4'h1)];
                     end
                  end
               end
            end
         end
      endcase

      // A set in the same cycle as a clear wins.
      rxReady_nxt = setRx ? 1'b1 : (clrRx ? 1'b0 : rxReady_r);
      overrun_nxt = setOvr ? 1'b1 : (clrOvr ? 1'b0 : overrun_r);
      txFull_nxt  = setTxFull ? 1'b1 : (loadTx ? 1'b0 : txFull_r);

      // Clearing the enable bit acts as a soft reset of the engine and its flags.
      if (!enable) begin
         state_nxt   = FWSP_IDLE;
         rxReady_nxt = 1'b0;
         overrun_nxt = 1'b0;
         txFull_nxt  = 1'b0;
         datPend_nxt = 1'b0;
      end

      intReq_nxt   = ctl_r[CTL_RX_IE] && (rxReady_nxt || overrun_nxt);
      pinOwned_nxt = enable;

      // Pin drive. The serial clock is at its idle level outside words.
      pinOut_nxt.sck  = polarity;
      if (master && (state_nxt == FWSP_XFER)) begin
         pinOut_nxt.sck = pinOut_r.sck;
         if (lead) begin
            pinOut_nxt.sck = !polarity;
         end
         if (trail) begin
            pinOut_nxt.sck = polarity;
         end
      end
      pinOut_nxt.simo = outBit_nxt;
      pinOut_nxt.somi = outBit_nxt;
      pinOut_nxt.ste  = !(master && (state_nxt == FWSP_XFER));
      pinOe_nxt.sck   = enable && master;
      pinOe_nxt.simo  = enable && master && talk;
      pinOe_nxt.somi  = enable && !master && talk && slvSel;
      pinOe_nxt.ste   = enable && master;
   end

   // -----------------------------------------------------------------------------------------
   // Registers
   // -----------------------------------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         cfg_r      <= CONFIG_RST;
         ctl_r      <= CONTROL_RST;
         rate_r     <= RATE_RST;
         for (int i = 0; i < MISC_NUM; i++) begin
            misc_r[i] <= BYTE_RST;
         end
         txBuf_r    <= BYTE_RST;
         txFull_r   <= 1'b0;
         rxBuf_r    <= BYTE_RST;
         rxReady_r  <= 1'b0;
         overrun_r  <= 1'b0;
         state_r    <= FWSP_IDLE;
         cnt_r      <= 4'h0;
         txSh_r     <= WORD_RST;
         rxSh_r     <= WORD_RST;
         outBit_r   <= 1'b0;
         first_r    <= 1'b0;
         datPend_r  <= 1'b0;
         sckPrev_r  <= 1'b0;
         pinOut_r   <= PIN_OUT_RST;
         pinOe_r    <= PIN_OE_RST;
         rdData_r   <= WORD_RST;
         pinOwned_r <= 1'b0;
         intReq_r   <= 1'b0;
      end else begin
         cfg_r      <= cfg_nxt;
         ctl_r      <= ctl_nxt;
         rate_r     <= rate_nxt;
         misc_r     <= misc_nxt;
         txBuf_r    <= txBuf_nxt;
         txFull_r   <= txFull_nxt;
         rxBuf_r    <= rxBuf_nxt;
         rxReady_r  <= rxReady_nxt;
         overrun_r  <= overrun_nxt;
         state_r    <= state_nxt;
         cnt_r      <= cnt_nxt;
         txSh_r     <= txSh_nxt;
         rxSh_r     <= rxSh_nxt;
         outBit_r   <= outBit_nxt;
         first_r    <= first_nxt;
         datPend_r  <= datPend_nxt;
         sckPrev_r  <= sckPrev_nxt;
         pinOut_r   <= pinOut_nxt;
         pinOe_r    <= pinOe_nxt;
         rdData_r   <= rdData_nxt;
         pinOwned_r <= pinOwned_nxt;
         intReq_r   <= intReq_nxt;
      end
   end

   assign rdData   = rdData_r;
   assign pinOut   = pinOut_r;
   assign pinOe    = pinOe_r;
   assign pinOwned = pinOwned_r;
   assign intReq   = intReq_r;

endmodule : fwsp_top
`default_nettype wire

// >>> sim/fwsp_top_sva.sv
// Checker: port-level properties of the four-wire serial port.
`timescale 1ns/10ps
`default_nettype none
module fwsp_top_sva (
   input wire logic                    clk_sys,
   input wire logic                    nrst,
   input wire fwsp_pkg::fwsp_bus_req_t busReq,
   input wire logic [15:0]             rdData,
   input wire fwsp_pkg::fwsp_pins_t    pinIn,
   input wire fwsp_pkg::fwsp_pins_t    pinOut,
   input wire fwsp_pkg::fwsp_pins_t    pinOe,
   input wire logic                    pinOwned,
   input wire logic                    intReq
);
   import fwsp_pkg::*;
   logic       prevSck_r, prevSck_nxt;
   logic [7:0] cntSck_r, cntSck_nxt;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   // ----------------------------------------------------------------
   // Serial clock period counter; it restarts on every rise in a word.
   // ----------------------------------------------------------------
   always_comb begin
      prevSck_nxt = pinOut.sck;
      cntSck_nxt = cntSck_r;
      if (pinOut.ste) cntSck_nxt = 8'h00;
      else if (pinOut.sck && !prevSck_r) cntSck_nxt = 8'h01;
      else if (cntSck_r != 8'h00 && cntSck_r != 8'hff) cntSck_nxt = cntSck_r + 8'h01;
   end
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         prevSck_r <= 1'b0;
         cntSck_r <= 8'h00;
      end else begin
         prevSck_r <= prevSck_nxt;
         cntSck_r <= cntSck_nxt;
      end
   end
   sequence seqSteIdle;
      (pinOe.ste && pinOut.ste) [*3];
   endsequence
   sequence seqSlaveDeselected;
      (pinOwned && !pinOe.ste && pinIn.ste) [*2];
   endsequence
   chk_pins_released: assert property (!pinOwned ##1 !pinOwned |-> pinOe == PIN_OE_RST)
      else $error("pin enables active while port not owned");
   chk_upper_zero: assert property (rdData[15:8] == 8'h00)
      else $error("read data upper byte not zero");
   chk_read_hold: assert property (!$past(busReq.rd) && !$past(busReq.rd, 2) |-> $stable(rdData))
      else $error("read data changed without a read");
   chk_unmapped_zero: assert property (busReq.rd && busReq.addr == 16'h7043 |-> ##2 rdData == WORD_RST)
      else $error("unmapped address read not zero");
   chk_master_pins: assert property (pinOe.ste |-> pinOe.sck && !pinOe.somi)
      else $error("master pin drive inconsistent");
   chk_slave_quiet: assert property (seqSlaveDeselected |-> !pinOe.somi)
      else $error("deselected slave drives its output");
   chk_sck_quiet: assert property (seqSteIdle |-> $stable(pinOut.sck))
      else $error("serial clock moved between words");
   chk_word_frame: assert property (pinOe.ste && $fell(pinOut.ste) |-> !pinOut.ste [*4])
      else $error("word frame shorter than one clock period");
   chk_sck_period: assert property (pinOe.ste && !pinOut.ste && pinOut.sck && !prevSck_r && cntSck_r != 8'h00
      |-> cntSck_r inside {[8'h04:8'h80]})
      else $error("serial clock period out of range");
endmodule : fwsp_top_sva
bind fwsp_top fwsp_top_sva u_fwsp_top_sva (.clk_sys(clk_sys), .nrst(nrst), .busReq(busReq), .rdData(rdData),
   .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .pinOwned(pinOwned), .intReq(intReq));
`default_nettype wire

// >>> sim/fwsp_peer_model.sv
// Peer model: an outside serial device answering the port while it is master.
`timescale 1ns/10ps
`default_nettype none
module fwsp_peer_model (
   input  wire logic        clk_sys,
   input  wire logic        sck,
   input  wire logic        simo,
   input  wire logic        ste,
   input  wire logic        pol,
   input  wire logic        phase,
   input  wire logic [4:0]  len,
   input  wire logic [15:0] txWord,
   output logic             somi,
   output logic [15:0]      rxWord
);
   logic       prevSck;
   logic       prevSte;
   logic       junk = 1'b0;
   logic [4:0] idx;
   logic       lead;
   logic       trail;
   // ----------------------------------------------------------------
   // Shift engine; the released line toggles so no stale bit is read.
   // ----------------------------------------------------------------
   assign lead = (sck ^ pol) && !(prevSck ^ pol);
   assign trail = !(sck ^ pol) && (prevSck ^ pol);
   assign somi = ste ? junk : txWord[idx];
   always @(posedge clk_sys) begin
      prevSck <= sck;
      prevSte <= ste;
      junk <= ~junk;
      // The last trailing edge arrives together with the select release.
      if (!prevSte && (phase ? lead : trail)) rxWord <= {rxWord[14:0], simo};
      if (ste) begin
         idx <= len - 5'd1;
      end else if (trail && idx != 5'd0) begin
         idx <= idx - 5'd1;
      end
   end
endmodule : fwsp_peer_model
`default_nettype wire

// >>> sim/fwsp_top_tb.sv
// Testbench: register access and master word transfers against a peer model.
`timescale 1ns/10ps
`default_nettype none
module fwsp_top_tb;
   import fwsp_pkg::*;
   logic          clk_sys, nrst, pinOwned, intReq, somiLine, mPol, mPh;
   logic [4:0]    mLen;
   logic [15:0]   rdData, mTx, mRx, d;
   fwsp_bus_req_t busReq;
   fwsp_pins_t    pinIn, pinOut, pinOe;
   logic          slvDrv, sSck, sSte, sSimo;
   logic [7:0]    sRx;
   int            failures, n_checks;
   int            rateT[5] = '{0, 2, 3, 9, 4};
   int            lenT[5] = '{1, 8, 16, 5, 8};
   logic          polT[5] = '{0, 1, 0, 1, 0};
   logic          phT[5] = '{0, 0, 1, 1, 1};
   logic          talkT[5] = '{1, 1, 1, 0, 1};
   logic          twT[5] = '{0, 0, 0, 0, 1};
   logic [15:0]   rstA[5] = '{OFS_CONFIG, OFS_CONTROL, OFS_STATUS, OFS_RATE, OFS_RX_BUF};
   // ----------------------------------------------------------------
   // Wiring; the select line idles high when nobody drives it.
   // ----------------------------------------------------------------
   assign pinIn = '{sck: slvDrv ? sSck : pinOut.sck,
                    simo: slvDrv ? sSimo : (pinOe.simo ? pinOut.simo : ~pinOut.sck), somi: somiLine,
                    ste: slvDrv ? sSte : (pinOe.ste ? pinOut.ste : 1'b1)};
   fwsp_peer_model u_fwsp_peer_model (.clk_sys(clk_sys), .sck(pinIn.sck), .simo(pinIn.simo), .ste(pinIn.ste),
      .pol(mPol), .phase(mPh), .len(mLen), .txWord(mTx), .somi(somiLine), .rxWord(mRx));
   fwsp_top u_fwsp_top (.clk_sys(clk_sys), .nrst(nrst), .busReq(busReq), .rdData(rdData), .pinIn(pinIn),
      .pinOut(pinOut), .pinOe(pinOe), .pinOwned(pinOwned), .intReq(intReq));
   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk16
   task automatic chk1(input logic got, input logic exp);
      chk16({15'h0000, got}, {15'h0000, exp});
   endtask : chk1
   task automatic busWr(input logic [15:0] a, input logic [15:0] v);
      @(negedge clk_sys);
      busReq = '{rd: 1'b0, wr: 1'b1, addr: a, data: v};
      @(negedge clk_sys);
      busReq.wr = 1'b0;
   endtask : busWr
   task automatic busRd(input logic [15:0] a);
      @(negedge clk_sys);
      busReq = '{rd: 1'b1, wr: 1'b0, addr: a, data: 16'h0000};
      @(negedge clk_sys);
      busReq.rd = 1'b0;
      @(negedge clk_sys);
      d = rdData;
   endtask : busRd
   task automatic runWord(input int k);
      int          per;
      int          r;
      logic        ps;
      logic [16:0] mask;
      mask = (17'h00001 << lenT[k]) - 17'h00001;
      mPol = polT[k];
      mPh = phT[k];
      mLen = 5'(lenT[k]);
      mTx = 16'hc35a ^ 16'(k);
      busWr(OFS_CONTROL, 16'h0000);
      busWr(OFS_CONFIG, {8'h00, 1'b1, polT[k], 2'b00, 4'(lenT[k] - 1)});
      busWr(OFS_RATE, 16'(rateT[k]));
      busWr(OFS_CONTROL, {11'h000, twT[k], phT[k], 1'b1, talkT[k], !talkT[k]});
      busWr(twT[k] ? OFS_SHIFT : OFS_TX_BUF, 16'hffa5);
      chk1(pinOe.simo, talkT[k]);
      per = 0;
      r = 0;
      ps = pinOut.sck;
      for (int i = 0; i < 200 && r < 2; i++) begin
         @(negedge clk_sys);
         if (r == 1) per++;
         if (pinOut.sck && !ps) r++;
         ps = pinOut.sck;
      end
      if (lenT[k] > 1) chk16(16'(per), (rateT[k] < 3) ? 16'h0004 : 16'(rateT[k] + 1));
      for (int i = 0; i < 100; i++) begin
         busRd(OFS_STATUS);
         if (d[STS_RX_READY] === 1'b1) break;
      end
      chk16(d & 16'h00e0, 16'h0040);
      chk1(intReq, !talkT[k]);
      busRd(OFS_RX_EMU);
      chk16(d, {8'h00, (twT[k] ? 8'ha5 : mTx[7:0]) & mask[7:0]});
      busRd(OFS_RX_BUF);
      chk16(d, {8'h00, (twT[k] ? 8'ha5 : mTx[7:0]) & mask[7:0]});
      chk1(intReq, 1'b0);
      if (talkT[k]) chk16(mRx & mask[15:0], 16'h00a5 & mask[15:0]);
   endtask : runWord
   // An outside master: two clocks per half period, select set up three clocks ahead.
   task automatic slvWord(input logic [7:0] tx);
      sSte = 1'b0;
      repeat (3) @(negedge clk_sys);
      chk1(pinOe.somi, 1'b1);
      for (int b = 7; b >= 0; b--) begin
         sSck = 1'b1;
         sSimo = tx[b];
         repeat (2) @(negedge clk_sys);
         sRx = {sRx[6:0], pinOut.somi};
         sSck = 1'b0;
         repeat (2) @(negedge clk_sys);
      end
      sSte = 1'b1;
   endtask : slvWord
   task automatic tally_and_finish();
      $display("checks=%0d failures=%0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : tally_and_finish
   // ----------------------------------------------------------------
   // Clock, watchdog and main sequence.
   // ----------------------------------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   initial begin
      repeat (20000) @(posedge clk_sys);
      failures++;
      tally_and_finish();
   end
   initial begin
      failures = 0;
      n_checks = 0;
      nrst = 1'b0;
      busReq = '0;
      mPol = 1'b0;
      mPh = 1'b0;
      mLen = 5'h08;
      mTx = 16'h0000;
      slvDrv = 1'b0;
      sSck = 1'b0;
      sSte = 1'b1;
      sSimo = 1'b0;
      repeat (12) @(negedge clk_sys);
      nrst = 1'b1;
      chk1(pinOwned, 1'b0);
      chk16({12'h000, pinOe}, 16'h0000);
      foreach (rstA[i]) begin
         busRd(rstA[i]);
         chk16(d, WORD_RST);
      end
      for (int i = 0; i < MISC_NUM; i++) begin
         busWr(MISC_OFS[i], 16'hff5a ^ 16'(i));
         busRd(MISC_OFS[i]);
         chk16(d, 16'h005a ^ 16'(i));
      end
      busWr(16'h7043, 16'h00ff);
      busRd(16'h7043);
      chk16(d, WORD_RST);
      for (int k = 0; k < 5; k++) runWord(k);
      busWr(OFS_CONTROL, 16'h0002);
      busWr(OFS_CONFIG, 16'h0087);
      busWr(OFS_TX_BUF, 16'h0096);
      slvDrv = 1'b1;
      slvWord(8'h3c);
      chk16({8'h00, sRx}, 16'h0096);
      repeat (2) @(negedge clk_sys);
      chk1(pinOe.somi, 1'b0);
      busRd(OFS_RX_BUF);
      chk16(d, 16'h003c);
      tally_and_finish();
   end
endmodule : fwsp_top_tb
`default_nettype wire
